/* File: design/tws_map.svh */
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// ****************************************************************
// register offsets on the plain register port
// ****************************************************************
`define TWS_OFS_OWN_ADDR 2'h0
`define TWS_OFS_CONTROL 2'h1
`define TWS_OFS_STATUS 2'h2
`define TWS_OFS_DATA 2'h3

// ****************************************************************
// control register fields
// ****************************************************************
`define TWS_CTL_FLAG 7
`define TWS_CTL_ACK_EN 6
`define TWS_CTL_START_REQ 5
`define TWS_CTL_WCOL 3
`define TWS_CTL_WMASK 8'h75
`define TWS_CTL_RESET 8'h00
`define TWS_OAR_RESET 8'h00
`define TWS_DATA_RESET 8'hFF

// ****************************************************************
// bus state codes, prescaler field always reads zero
// ****************************************************************
`define TWS_SC_OWN_ACK 8'h60
`define TWS_SC_ARB_OWN 8'h68
`define TWS_SC_GC_ACK 8'h70
`define TWS_SC_ARB_GC 8'h78
`define TWS_SC_OWN_DATA_ACK 8'h80
`define TWS_SC_OWN_DATA_NACK 8'h88
`define TWS_SC_GC_DATA_ACK 8'h90
`define TWS_SC_GC_DATA_NACK 8'h98
`define TWS_SC_STOP 8'hA0
`define TWS_SC_IDLE 8'hF8
`define TWS_GC_ADDR 7'h00
`define TWS_BITS_PER_BYTE 4'h8

`endif

/* File: design/tws_pkg.sv */
package tws_pkg;

  // ****************************************************************
  // receiver sequencing states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_HOLD = 3'b011,
    ST_DATA = 3'b100,
    ST_DACK = 3'b101
  } tws_state_t;

  // one bit per bus wire, used for inputs, outputs and enables alike
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_t;

  // control register layout, msb first
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic wcol;
    logic enable;
    logic rsvd;
    logic irq_en;
  } tws_ctrl_t;

endpackage

/* File: design/tws_slave_rx.sv */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_slave_rx (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire tws_pkg::tws_line_t line_i,
  output tws_pkg::tws_line_t line_o,
  output tws_pkg::tws_line_t line_oe_n_o,
  input wire logic sleep_i,
  input wire logic arb_lost_i,
  output logic wake_o,
  output logic start_go_o
);
  import tws_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // status after the address acknowledge
  function automatic logic [7:0] addr_code(input logic own, input logic arb);
    logic [7:0] c;
    c = own ? `TWS_SC_OWN_ACK : `TWS_SC_GC_ACK;
    if (arb)
    begin
      c = own ? `TWS_SC_ARB_OWN : `TWS_SC_ARB_GC;
    end
    return c;
  endfunction

  // status after a data byte
  function automatic logic [7:0] data_code(input logic own, input logic ack);
    logic [7:0] c;
    if (own)
    begin
      c = ack ? `TWS_SC_OWN_DATA_ACK : `TWS_SC_OWN_DATA_NACK;
    end
    else
    begin
      c = ack ? `TWS_SC_GC_DATA_ACK : `TWS_SC_GC_DATA_NACK;
    end
    return c;
  endfunction

  // codes after which the slave drops out of the addressed state
  function automatic logic is_leave_code(input logic [7:0] c);
    return (c == `TWS_SC_OWN_DATA_NACK) || (c == `TWS_SC_GC_DATA_NACK) ||
      (c == `TWS_SC_STOP);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  tws_line_t line_s1_r;
  tws_line_t line_s2_r;
  tws_line_t line_s3_r;
  tws_ctrl_t ctl_r;
  logic [7:0] oar_r;
  logic [7:0] status_r;
  logic [7:0] data_r;
  logic [7:0] shreg_r;
  logic [3:0] bit_cnt_r;
  tws_state_t state_r;
  logic own_r;
  logic arb_r;
  logic ack_r;
  logic start_pend_r;
  logic bus_free_r;

  tws_state_t state_nxt;
  logic [7:0] shreg_nxt;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] status_nxt;
  logic own_nxt;
  logic arb_nxt;
  logic ack_nxt;
  logic sda_oe_n_nxt;
  logic scl_oe_n_nxt;
  logic ev_set;
  logic load_data;
  logic load_addr;

  // ****************************************************************
  // bus line decoding
  // ****************************************************************

  // edges read stages two and three only, stage one is the metastability stage
  wire scl_rise = line_s2_r.scl & ~line_s3_r.scl;
  wire scl_fall = ~line_s2_r.scl & line_s3_r.scl;
  wire scl_hi = line_s2_r.scl & line_s3_r.scl;
  wire start_det = scl_hi & line_s3_r.sda & ~line_s2_r.sda;
  wire stop_det = scl_hi & ~line_s3_r.sda & line_s2_r.sda;
  wire byte_done = (bit_cnt_r == `TWS_BITS_PER_BYTE);

  // address recognition, gated by ack_enable so the bus is only watched
  wire own_match = (shreg_r[7:1] == oar_r[7:1]);
  wire gc_match = oar_r[0] & (shreg_r[7:1] == `TWS_GC_ADDR);
  wire write_dir = ~shreg_r[0];
  wire addr_hit = ctl_r.ack_en & write_dir & (own_match | gc_match);
  wire leaving = is_leave_code(status_r);
  wire addressed = (state_r == ST_AACK) || (state_r == ST_DATA) ||
    (state_r == ST_DACK) || ((state_r == ST_HOLD) && !leaving);

  // ****************************************************************
  // register port decoding
  // ****************************************************************
  wire wr_oar = wr_i && (addr_i == `TWS_OFS_OWN_ADDR);
  wire wr_ctl = wr_i && (addr_i == `TWS_OFS_CONTROL);
  wire wr_data = wr_i && (addr_i == `TWS_OFS_DATA);
  wire flag_clr = wr_ctl && wdata_i[`TWS_CTL_FLAG];
  wire [7:0] rd_mux = (addr_i == `TWS_OFS_OWN_ADDR) ? oar_r :
    (addr_i == `TWS_OFS_CONTROL) ? ctl_r :
    (addr_i == `TWS_OFS_STATUS) ? status_r : data_r;

  // ****************************************************************
  // receiver sequencing
  // ****************************************************************

  // stop and start are checked right after enable, before the states: they can occur in any bus phase
  always_comb
  begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    bit_cnt_nxt = bit_cnt_r;
    status_nxt = status_r;
    own_nxt = own_r;
    arb_nxt = arb_r;
    ack_nxt = ack_r;
    sda_oe_n_nxt = line_oe_n_o.sda;
    scl_oe_n_nxt = line_oe_n_o.scl;
    ev_set = 1'b0;
    load_data = 1'b0;
    load_addr = 1'b0;
    if (!ctl_r.enable)
    begin
      state_nxt = ST_IDLE;
      sda_oe_n_nxt = 1'b1;
      scl_oe_n_nxt = 1'b1;
    end
    else if (stop_det || start_det)
    begin
      state_nxt = start_det ? ST_ADDR : ST_IDLE;
      bit_cnt_nxt = 4'h0;
      sda_oe_n_nxt = 1'b1;
      if (addressed)
      begin
        ev_set = 1'b1;
        status_nxt = `TWS_SC_STOP;
      end
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          bit_cnt_nxt = 4'h0;
        end
        ST_ADDR:
        begin
          if (scl_rise && !byte_done)
          begin
            shreg_nxt = {shreg_r[6:0], line_s2_r.sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            if (addr_hit)
            begin
              sda_oe_n_nxt = 1'b0;
              own_nxt = own_match;
              arb_nxt = arb_lost_i;
              load_addr = ~sleep_i;
              state_nxt = ST_AACK;
            end
            else
            begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            sda_oe_n_nxt = 1'b1;
            scl_oe_n_nxt = 1'b0;
            ev_set = 1'b1;
            status_nxt = addr_code(own_r, arb_r);
            state_nxt = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (!ctl_r.flag)
          begin
            scl_oe_n_nxt = 1'b1;
            bit_cnt_nxt = 4'h0;
            ack_nxt = ctl_r.ack_en;
            state_nxt = leaving ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (scl_rise && !byte_done)
          begin
            shreg_nxt = {shreg_r[6:0], line_s2_r.sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            load_data = 1'b1;
            sda_oe_n_nxt = ~ack_r;
            state_nxt = ST_DACK;
          end
        end
        ST_DACK:
        begin
          if (scl_fall)
          begin
            sda_oe_n_nxt = 1'b1;
            scl_oe_n_nxt = 1'b0;
            ev_set = 1'b1;
            status_nxt = data_code(own_r, ack_r);
            state_nxt = ST_HOLD;
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
          sda_oe_n_nxt = 1'b1;
          scl_oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // pin synchronisers and bus engine registers
  // ****************************************************************

  // two flops per pin; a third copy only serves the edge detectors
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      line_s1_r <= '1;
      line_s2_r <= '1;
      line_s3_r <= '1;
      line_o <= '0;
      line_oe_n_o <= '1;
      state_r <= ST_IDLE;
      shreg_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      own_r <= 1'b0;
      arb_r <= 1'b0;
      ack_r <= 1'b0;
    end
    else if (ce_i)
    begin
      line_s1_r <= line_i;
      line_s2_r <= line_s1_r;
      line_s3_r <= line_s2_r;
      line_o <= '0; // open drain: only the enables move
      line_oe_n_o <= '{scl: scl_oe_n_nxt, sda: sda_oe_n_nxt};
      state_r <= state_nxt;
      shreg_r <= shreg_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      own_r <= own_nxt;
      arb_r <= arb_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************

  // a hardware set in the same cycle as a software clear keeps the flag set
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      oar_r <= `TWS_OAR_RESET;
      ctl_r <= `TWS_CTL_RESET;
      status_r <= `TWS_SC_IDLE;
      data_r <= `TWS_DATA_RESET;
      rdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_oar)
      begin
        oar_r <= wdata_i;
      end
      if (wr_ctl)
      begin
        ctl_r <= (ctl_r & ~`TWS_CTL_WMASK) | (wdata_i & `TWS_CTL_WMASK);
      end
      ctl_r.flag <= ev_set | (ctl_r.flag & ~flag_clr);
      if (wr_data)
      begin
        ctl_r.wcol <= ~ctl_r.flag; // data written while busy is a collision
      end
      status_r <= status_nxt & 8'hF8;
      if (load_data || load_addr)
      begin
        data_r <= shreg_r;
      end
      else if (wr_data && ctl_r.flag)
      begin
        data_r <= wdata_i;
      end
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // wake-up and deferred start
  // ****************************************************************

  // the pending start is handed to master logic as a pulse once the bus is free;
  // a long system start-up keeps SCL low for that whole time, blocking the bus
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wake_o <= 1'b0;
      start_pend_r <= 1'b0;
      bus_free_r <= 1'b1;
      start_go_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (ev_set && (state_r == ST_AACK) && sleep_i)
      begin
        wake_o <= 1'b1;
      end
      else if (!ctl_r.flag)
      begin
        wake_o <= 1'b0;
      end
      if (stop_det)
      begin
        bus_free_r <= 1'b1;
      end
      else if (start_det)
      begin
        bus_free_r <= 1'b0;
      end
      start_go_o <= 1'b0;
      if (flag_clr && ctl_r.flag && leaving && wdata_i[`TWS_CTL_START_REQ])
      begin
        start_pend_r <= 1'b1;
      end
      else if (start_pend_r && bus_free_r && (state_r == ST_IDLE))
      begin
        start_pend_r <= 1'b0;
        start_go_o <= 1'b1;
      end
    end
  end

endmodule

/* File: verification/tws_slave_rx_assertions.sv */
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire tws_pkg::tws_line_t line_i,
  input wire tws_pkg::tws_line_t line_oe_n_o,
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic start_go_o
);
  import tws_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ****
  // flag clear tracking, the stretch may take two cycles to let go
  // ****
  logic clr;
  logic [1:0] clr_q;
  assign clr = wr_i && addr_i == `TWS_OFS_CONTROL && wdata_i[`TWS_CTL_FLAG];
  // short history of flag clears
  always_ff @(posedge clk_i)
  begin
    clr_q <= {clr_q[0], clr};
  end
  // ****
  // checks
  // ****
  hold_low_a: assert property (
    !line_oe_n_o.scl && !clr && clr_q == 2'b00 |=> !line_oe_n_o.scl)
    else $error("clock stretch dropped without flag clear");
  release_a: assert property (clr && !line_oe_n_o.scl |-> ##[1:3] line_oe_n_o.scl)
    else $error("clock stretch kept after flag clear");
  wake_clr_a: assert property (wake_o && clr |-> ##[1:2] !wake_o)
    else $error("wake kept after flag clear");
  wake_src_a: assert property ($rose(wake_o) |-> $past(sleep_i))
    else $error("wake raised while awake");
  // wake and stretch both let go two edges after the clear, so the clear's echo is excluded
  wake_hold_a: assert property (
    wake_o && !line_oe_n_o.scl && !clr && !clr_q[0] |=> wake_o)
    else $error("wake dropped while stretched");
  sda_edge_a: assert property (
    $changed(line_oe_n_o.sda) |-> !line_i.scl && !$past(line_i.scl))
    else $error("data line moved while clock high");
  ack_len_a: assert property ($fell(line_oe_n_o.sda) |-> !line_oe_n_o.sda [*8])
    else $error("acknowledge too short");
  stretch_ack_a: assert property ($rose(line_oe_n_o.sda) |-> !line_oe_n_o.scl)
    else $error("no stretch after acknowledge");
  go_pulse_a: assert property (start_go_o |-> line_i.scl && line_i.sda ##1 !start_go_o)
    else $error("start request pulse wrong");
  cover property ($rose(wake_o));
  cover property (start_go_o);
  cover property ($fell(line_oe_n_o.sda));
endmodule

/* File: verification/tws_master_model.sv */
`timescale 1ns/1ps
module tws_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // released lines rise through the pull-ups; clock stands still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start: data falls while clock high
  task start();
    sda_o = 1'b0;
    #80;
    scl_o = 1'b0;
    #40;
  endtask
  // stop: data rises while clock high, waits out a stretch first
  task stop();
    sda_o = 1'b0;
    #40;
    scl_o = 1'b1;
    wait (scl_i);
    #80;
    sda_o = 1'b1;
    #80;
  endtask
  // byte msb first plus ack slot; data only moves while the clock is low
  task xfer(input logic [7:0] b, output logic nack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_o = (i == 0) ? 1'b1 : b[i-1];
      #40;
      scl_o = 1'b1;
      wait (scl_i);
      #40;
      nack = sda_i;
      #40;
      scl_o = 1'b0;
      #40;
    end
  endtask
endmodule

/* File: verification/tws_slave_rx_tb_top.sv */
`timescale 1ns/1ps
module tws_slave_rx_tb_top;
  import tws_pkg::*;
  logic clk_i, resetn_i, wr_i, rd_i, sleep_i, arb_lost_i, nk, m_scl, m_sda, wake_o, start_go_o;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic [6:0] own;
  logic [7:0] rst_v [4] = '{8'h00, 8'h00, 8'hF8, 8'hFF};
  tws_line_t bus_w, line_o, oe_n;
  int errors, compares;
  // ****
  // wired-and bus and instances
  // ****
  assign bus_w = {m_scl & oe_n.scl, m_sda & oe_n.sda};
  tws_slave_rx u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_i(bus_w),
    .line_o(line_o), .line_oe_n_o(oe_n), .sleep_i(sleep_i), .arb_lost_i(arb_lost_i),
    .wake_o(wake_o), .start_go_o(start_go_o));
  tws_master u_m (.scl_i(bus_w.scl), .sda_i(bus_w.sda), .scl_o(m_scl), .sda_o(m_sda));
  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ****
  // register port and comparison tasks
  // ****
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // the master reads NACK for a refused address and for the not-acknowledged codes
  function automatic logic [7:0] exp_nack(input logic [7:0] sc);
    return {7'h0, (sc == 8'h00) || (sc == 8'h88) || (sc == 8'h98)};
  endfunction
  // poll the control register, bounded
  task wait_flag();
    d = 8'h00;
    for (int i = 0; i < 2000 && d[7] !== 1'b1; i++) rd(2'h1, d);
    chk("flag", d & 8'h80, 8'h80);
  endtask
  // ****
  // bus scenarios; a zero code means the address must be refused
  // ****
  task addr_ph(input logic [7:0] b, input logic [7:0] sc);
    u_m.start();
    u_m.xfer(b, nk);
    chk("addr ack", {7'h0, nk}, exp_nack(sc));
    if (sc == 8'h00) u_m.stop();
    else
    begin
      wait_flag();
      rd(2'h2, d);
      chk("status", d, sc);
      chk("stretch", {7'h0, oe_n.scl}, 8'h00);
      chk("drive level", {6'h0, line_o}, 8'h00);
    end
  endtask
  task data_ph(input logic [7:0] ctl, input logic [7:0] sc);
    logic [7:0] b;
    b = 8'($urandom);
    fork
      u_m.xfer(b, nk);
      wr(2'h1, ctl);
    join
    wait_flag();
    rd(2'h2, d);
    chk("status", d, sc);
    rd(2'h3, d);
    chk("data", d, b);
    chk("data ack", {7'h0, nk}, exp_nack(sc));
  endtask
  task end_frame(input logic a0, input logic [7:0] ctl);
    fork
      u_m.stop();
      wr(2'h1, 8'hC4);
    join
    if (a0)
    begin
      wait_flag();
      rd(2'h2, d);
      chk("status", d, 8'hA0);
      wr(2'h1, ctl);
    end
  endtask
  task complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #500000;
    errors++;
    complete_run();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    {errors, compares} = '0;
    {resetn_i, wr_i, rd_i, sleep_i, arb_lost_i, addr_i, wdata_i} = '0;
    void'($urandom(32'h966A));
    own = 7'($urandom_range(127, 1));
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      rd(2'(i), d);
      chk("reset value", d, rst_v[i]);
    end
    chk("released", {6'h0, oe_n}, 8'h03);
    wr(2'h1, 8'hFF);
    rd(2'h1, d);
    chk("control mask", d, 8'h75);
    wr(2'h3, 8'h5A);
    rd(2'h1, d);
    chk("collision", d, 8'h7D);
    wr(2'h0, {own, 1'b0});
    wr(2'h1, 8'h44);
    addr_ph({own ^ 7'h01, 1'b0}, 8'h00);
    addr_ph(8'h00, 8'h00);
    addr_ph({own, 1'b1}, 8'h00);
    wr(2'h1, 8'h04);
    addr_ph({own, 1'b0}, 8'h00);
    wr(2'h1, 8'h44);
    addr_ph({own, 1'b0}, 8'h60);
    repeat (3) data_ph(8'hC4, 8'h80);
    data_ph(8'h84, 8'h88);
    end_frame(1'b0, 8'h00);
    wr(2'h0, {own, 1'b1});
    addr_ph(8'h00, 8'h70);
    data_ph(8'hC4, 8'h90);
    data_ph(8'h84, 8'h98);
    end_frame(1'b0, 8'h00);
    addr_ph(8'h00, 8'h70);
    data_ph(8'hC4, 8'h90);
    end_frame(1'b1, 8'hE4);
    #1;
    for (int i = 0; i < 100 && start_go_o !== 1'b1; i++) @(posedge clk_i) #1;
    chk("start go", {7'h0, start_go_o}, 8'h01);
    wr(2'h1, 8'h44);
    @(posedge clk_i) arb_lost_i <= 1'b1;
    addr_ph({own, 1'b0}, 8'h68);
    end_frame(1'b1, 8'hC4);
    addr_ph(8'h00, 8'h78);
    end_frame(1'b1, 8'hC4);
    @(posedge clk_i) {arb_lost_i, sleep_i} <= 2'b01;
    addr_ph({own, 1'b0}, 8'h60);
    chk("wake", {7'h0, wake_o}, 8'h01);
    // the general call address taken awake left 0x00; the sleeping address must not load
    rd(2'h3, d);
    chk("sleep data", d, 8'h00);
    @(posedge clk_i) sleep_i <= 1'b0;
    data_ph(8'hC4, 8'h80);
    chk("wake", {7'h0, wake_o}, 8'h00);
    end_frame(1'b1, 8'hC4);
    complete_run();
  end
endmodule
bind tws_slave_rx tws_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .line_i(line_i), .line_oe_n_o(line_oe_n_o),
  .sleep_i(sleep_i), .wake_o(wake_o), .start_go_o(start_go_o));
